// ==== verilog/ncosl_pkg.sv ====
// Constants, field positions and types of the NCO select/latency core.
// Assumes one master clock and 32-bit APB word access.
package ncosl_pkg;

    // ==========================================================
    // Widths
    localparam int ACC_W  = 32;
    localparam int PH_W   = 12;
    localparam int ADDR_W = 8;
    localparam int TAP_W  = 3;

    // ==========================================================
    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_FREQ0   = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_FREQ1   = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_PHASE0  = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_PHASE3  = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_CMD     = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_SELBITS = 8'h1C;
    localparam logic [ADDR_W-1:0] OFS_STATUS  = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_OUTWORD = 8'h24;
    localparam logic [ADDR_W-1:0] OFS_ACC     = 8'h28;

    // ==========================================================
    // Command word fields
    localparam int          CMD_OP_HI  = 15;
    localparam int          CMD_OP_LO  = 14;
    localparam logic [1:0]  CMD_OP_SYNC = 2'h2;
    localparam logic [1:0]  CMD_OP_PWR  = 2'h3;
    localparam int          BIT_SYNC   = 13;
    localparam int          BIT_SELECT_SOURCE = 12;
    localparam int          BIT_SLEEP  = 13;
    localparam int          BIT_RESET  = 12;
    localparam int          BIT_CLEAR  = 11;

    // Select bits register and status fields
    localparam int SELB_FREQ  = 0;
    localparam int SELB_PLSB  = 1;
    localparam int SELB_PMSB  = 2;
    localparam int ST_RESYNC  = 0;
    localparam int ST_SELECT_SOURCE  = 1;
    localparam int ST_SLEEP   = 2;
    localparam int ST_RESET   = 3;
    localparam int ST_HOLD    = 4;
    localparam int ST_SEL_LO  = 8;

    // ==========================================================
    // Latencies in master clock cycles
    localparam int SYNC_STAGES     = 2;
    localparam int SEL_LAT_DIRECT  = 6;
    localparam int SEL_LAT_RESYNC  = 8;
    localparam int LOAD_LAT_DIRECT = 6;
    localparam int LOAD_LAT_RESYNC = 8;
    localparam int RUN_LAT         = 6;
    // Pipe taps: select path also spends the active and output registers
    localparam int SEL_TAP_DIRECT  = SEL_LAT_DIRECT - SYNC_STAGES - 2;
    localparam int SEL_TAP_RESYNC  = SEL_LAT_RESYNC - SYNC_STAGES - 2;
    localparam int LOAD_TAP_DIRECT = LOAD_LAT_DIRECT - 1;
    localparam int LOAD_TAP_RESYNC = LOAD_LAT_RESYNC - 1;
    localparam int RUN_CNT_W       = 3;
    localparam logic [RUN_CNT_W-1:0] RUN_RELOAD = 3'(RUN_LAT - 1);
    localparam int STEADY_W        = 4;

    // Reset values
    localparam logic RST_RESET_CTL = 1'b1;

    // ==========================================================
    // Types
    typedef struct packed {
        logic [1:0] phase;
        logic       freq;
    } ncosl_sel_type;

    typedef struct packed {
        logic             valid;
        logic [2:0]       idx;
        logic [ACC_W-1:0] data;
    } ncosl_load_type;

endpackage

// ==== verilog/ncosl_reg_if.sv ====
// Register access link between the APB slave and the NCO core.
// Assumes both ends on mclk.
`timescale 1ns/1ns
`default_nettype none
interface ncosl_reg_if;
    import ncosl_pkg::*;
    logic              wr_stb;
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
    logic [31:0]       rdata;
    logic              hit;
    modport bus  (output wr_stb, output addr, output wdata, input rdata, input hit);
    modport core (input wr_stb, input addr, input wdata, output rdata, output hit);
endinterface
`default_nettype wire

// ==== verilog/ncosl_delay.sv ====
// Shift-register delay line with a selectable tap.
// Assumes tap between 1 and DEPTH; all words on mclk.
`timescale 1ns/1ns
`default_nettype none
module ncosl_delay #(
    parameter int W     = 8,
    parameter int DEPTH = 8,
    parameter int TAP_W = 4
) (
    input  wire logic             mclk,
    input  wire logic             nrst,
    input  wire logic [W-1:0]     in_data,
    input  wire logic [TAP_W-1:0] tap,
    output logic      [W-1:0]     out_data
);
    import ncosl_pkg::*;

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] stage;
    } ncosl_dly_state_type;

    ncosl_dly_state_type state_reg;
    ncosl_dly_state_type state_next;

    // ==========================================================
    // Shift one stage per clock
    always_comb begin
        state_next       = state_reg;
        state_next.stage = {state_reg.stage[DEPTH-2:0], in_data};
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // Word that has passed tap stages
    assign out_data = state_reg.stage[tap - 1'b1];
endmodule
`default_nettype wire

// ==== verilog/ncosl_apb.sv ====
// APB slave front end of the NCO core.
// Assumes psel/penable follow APB; zero wait states on access.
`timescale 1ns/1ns
`default_nettype none
module ncosl_apb (
    input  wire logic                     mclk,
    input  wire logic                     nrst,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [ncosl_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]              pwdata,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    ncosl_reg_if.bus                      regs
);
    import ncosl_pkg::*;

    typedef struct packed {
        logic [31:0] rdata;
    } ncosl_apb_state_type;

    ncosl_apb_state_type state_reg;
    ncosl_apb_state_type state_next;

    // ==========================================================
    // Read data captured in the setup cycle
    always_comb begin
        state_next = state_reg;
        if (psel && !penable && !pwrite) begin
            state_next.rdata = regs.hit ? regs.rdata : 32'h0000_0000;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // Access phase always completes at once
    assign regs.addr   = paddr;
    assign regs.wdata  = pwdata;
    assign regs.wr_stb = psel & penable & pwrite & regs.hit;
    assign pready      = psel & penable;
    assign pslverr     = psel & penable & ~regs.hit;
    assign prdata      = state_reg.rdata;
endmodule
`default_nettype wire

// ==== verilog/ncosl_top.sv ====
// NCO select/latency control core: accumulator, offset, register select.
// Assumes APB master on mclk and select pins asynchronous to mclk.
//
// Contract
// - Select change controls output six cycles later, resync off; a frequency select change reaches phase_word after seven.
// - Select change controls output eight cycles later, resync on; a frequency select change reaches phase_word after nine.
// - Late pin change may add one cycle via synchroniser.
// - Load of selected register reaches output after 6 or 7 cycles.
// - With resync on, load reaches output after 8 or 9 cycles.
// - Reset bit holds accumulator and output at zero phase; while sleep is set the code freezes them at their last values instead.
// - Clear command zeroes resync and select source.
// - Reset bit leaves frequency and phase registers unchanged.
// - Output starts changing six cycles after reset bit clears.
// - Accumulator adds selected frequency word every cycle.
// - Selected 12-bit phase offset added before lookup.
// - Two frequency registers, chosen by freq_select.
// - Four phase registers, chosen by two phase-select inputs.
// - Command 10: D13 sets resync, D12 sets select source.
// - Command 11: D13 sleep, D12 reset, D11 self-clearing clear.
//
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module ncosl_top (
    input  wire logic                         mclk,
    input  wire logic                         nrst,
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [ncosl_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                  pwdata,
    output logic      [31:0]                  prdata,
    output logic                              pready,
    output logic                              pslverr,
    input  wire logic                         freq_select,
    input  wire logic                         phase_select_lsb,
    input  wire logic                         phase_select_msb,
    output logic      [ncosl_pkg::PH_W-1:0]   phase_word,
    output logic                              sleep_active
);
    import ncosl_pkg::*;

    typedef struct packed {
        logic [1:0][ACC_W-1:0]             freq;
        logic [3:0][PH_W-1:0]              phase;
        logic                              resync;
        logic                              select_source;
        logic                              sleep;
        logic                              reset_ctl;
        ncosl_sel_type                     sel_bits;
        logic [SYNC_STAGES-1:0][2:0]       bits_dly;
        logic [2:0]                        pin_s1;
        logic [2:0]                        pin_s2;
        ncosl_sel_type                     sel_active;
        logic [ACC_W-1:0]                  acc;
        logic [PH_W-1:0]                   out_word;
        logic [RUN_CNT_W-1:0]              run_cnt;
        logic [STEADY_W-1:0]               steady;
    } ncosl_state_type;

    ncosl_state_type state_reg;
    ncosl_state_type state_next;

    ncosl_reg_if     regs ();

    ncosl_sel_type   sel_src;
    ncosl_sel_type   sel_piped;
    ncosl_load_type  ld_in;
    ncosl_load_type  ld_out;
    logic [TAP_W-1:0] sel_tap;
    logic [TAP_W-1:0] ld_tap;
    logic            hold;
    logic            cmd_wr;
    logic [ACC_W-1:0] freq_sel;
    logic [PH_W-1:0] phase_sel;

    // ==========================================================
    // Address decode
    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        logic ok;
        ok = (a[1:0] == 2'h0) && (a <= OFS_ACC);
        return ok;
    endfunction

    function automatic logic is_word_reg(input logic [ADDR_W-1:0] a);
        logic ok;
        ok = (a[1:0] == 2'h0) && (a <= OFS_PHASE3);
        return ok;
    endfunction

    // ==========================================================
    // Bus front end
    ncosl_apb u_apb (
        .mclk    (mclk),
        .nrst    (nrst),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr),
        .regs    (regs.bus)
    );

    assign regs.hit = is_mapped(regs.addr);
    assign cmd_wr   = regs.wr_stb && (regs.addr == OFS_CMD);

    // ==========================================================
    // Select source and pipeline
    // Pins or bits, both two cycles old
    assign sel_src = state_reg.select_source ? ncosl_sel_type'(state_reg.bits_dly[SYNC_STAGES-1])
                                      : ncosl_sel_type'(state_reg.pin_s2);
    // Tap grows by two with resync
    assign sel_tap = state_reg.resync ? TAP_W'(SEL_TAP_RESYNC)
                                      : TAP_W'(SEL_TAP_DIRECT);

    ncosl_delay #(
        .W     (3),
        .DEPTH (SEL_TAP_RESYNC),
        .TAP_W (TAP_W)
    ) u_sel_pipe (
        .mclk     (mclk),
        .nrst     (nrst),
        .in_data  (sel_src),
        .tap      (sel_tap),
        .out_data (sel_piped)
    );

    // ==========================================================
    // Load pipeline for frequency and phase words
    always_comb begin
        ld_in       = '0;
        ld_in.valid = regs.wr_stb && is_word_reg(regs.addr);
        ld_in.idx   = regs.addr[4:2];
        ld_in.data  = regs.wdata;
    end
    assign ld_tap = state_reg.resync ? TAP_W'(LOAD_TAP_RESYNC)
                                     : TAP_W'(LOAD_TAP_DIRECT);

    ncosl_delay #(
        .W     ($bits(ncosl_load_type)),
        .DEPTH (LOAD_TAP_RESYNC),
        .TAP_W (TAP_W)
    ) u_load_pipe (
        .mclk     (mclk),
        .nrst     (nrst),
        .in_data  (ld_in),
        .tap      (ld_tap),
        .out_data (ld_out)
    );

    // ==========================================================
    // Register selection and output hold
    assign freq_sel  = state_reg.freq[state_reg.sel_active.freq];
    assign phase_sel = state_reg.phase[state_reg.sel_active.phase];
    assign hold      = state_reg.reset_ctl || (state_reg.run_cnt != '0);

    // ==========================================================
    // Next state of the core
    always_comb begin
        state_next = state_reg;
        // Two-flop pin synchroniser; late edges slip a cycle
        state_next.pin_s1 = {phase_select_msb, phase_select_lsb, freq_select};
        state_next.pin_s2 = state_reg.pin_s1;
        state_next.bits_dly = {state_reg.bits_dly[SYNC_STAGES-2:0], state_reg.sel_bits};
        state_next.sel_active = sel_piped;
        // Committed loads; phase keeps its low 12 bits
        if (ld_out.valid) begin
            if (ld_out.idx < 3'h2) begin
                state_next.freq[ld_out.idx[0]] = ld_out.data;
            end else begin
                state_next.phase[2'(ld_out.idx - 3'h2)] = ld_out.data[PH_W-1:0];
            end
        end
        // Select bits register
        if (regs.wr_stb && (regs.addr == OFS_SELBITS)) begin
            state_next.sel_bits = {regs.wdata[SELB_PMSB], regs.wdata[SELB_PLSB],
                                   regs.wdata[SELB_FREQ]};
        end
        // Command words; reset bit touches no data register
        if (cmd_wr) begin
            unique case (regs.wdata[CMD_OP_HI:CMD_OP_LO])
                CMD_OP_SYNC: begin
                    state_next.resync = regs.wdata[BIT_SYNC];
                    state_next.select_source = regs.wdata[BIT_SELECT_SOURCE];
                end
                CMD_OP_PWR: begin
                    state_next.sleep     = regs.wdata[BIT_SLEEP];
                    state_next.reset_ctl = regs.wdata[BIT_RESET];
                    if (regs.wdata[BIT_CLEAR]) begin
                        state_next.resync = 1'b0;
                        state_next.select_source = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        // Start-up delay after the reset bit clears
        if (state_reg.reset_ctl) begin
            state_next.run_cnt = RUN_RELOAD;
        end else if (state_reg.run_cnt != '0) begin
            state_next.run_cnt = state_reg.run_cnt - 1'b1;
        end
        // Accumulator and phase word; sleep freezes both
        if (!state_reg.sleep) begin
            if (hold) begin
                state_next.acc      = '0;
                state_next.out_word = '0;
            end else begin
                state_next.acc      = state_reg.acc + freq_sel;
                state_next.out_word = state_reg.acc[ACC_W-1 -: PH_W] + phase_sel;
            end
        end
        // Cycles since resync last changed
        if (state_next.resync != state_reg.resync) begin
            state_next.steady = '0;
        end else if (state_reg.steady != '1) begin
            state_next.steady = state_reg.steady + 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_reg           <= '0;
            state_reg.reset_ctl <= RST_RESET_CTL;
        end else begin
            state_reg <= state_next;
        end
    end

    // ==========================================================
    // Read mux
    always_comb begin
        regs.rdata = 32'h0000_0000;
        if (regs.addr <= OFS_FREQ1) begin
            regs.rdata = state_reg.freq[regs.addr[2]];
        end else if (regs.addr <= OFS_PHASE3) begin
            regs.rdata[PH_W-1:0] = state_reg.phase[2'(regs.addr[4:2] - 3'h2)];
        end else if ((regs.addr == OFS_CMD) || (regs.addr == OFS_STATUS)) begin
            regs.rdata[ST_RESYNC] = state_reg.resync;
            regs.rdata[ST_SELECT_SOURCE] = state_reg.select_source;
            regs.rdata[ST_SLEEP]  = state_reg.sleep;
            regs.rdata[ST_RESET]  = state_reg.reset_ctl;
            regs.rdata[ST_HOLD]   = hold;
            regs.rdata[ST_SEL_LO +: 3] = state_reg.sel_active;
        end else if (regs.addr == OFS_SELBITS) begin
            regs.rdata[2:0] = state_reg.sel_bits;
        end else if (regs.addr == OFS_OUTWORD) begin
            regs.rdata[PH_W-1:0] = state_reg.out_word;
        end else begin
            regs.rdata = state_reg.acc;
        end
    end

    // Outputs straight from flip-flops
    assign phase_word   = state_reg.out_word;
    assign sleep_active = state_reg.sleep;

    // ==========================================================
    // Assertions
    default clocking ast_clk @(posedge mclk); endclocking
    default disable iff (!nrst);

    AST_SEL_DIRECT: assert property (
        (state_reg.steady > 4'h9 && !state_reg.resync)
            |-> state_reg.sel_active == $past(sel_src, 3))
        else $error("select latency wrong without resync");

    AST_SEL_RESYNC: assert property (
        (state_reg.steady > 4'h9 && state_reg.resync)
            |-> state_reg.sel_active == $past(sel_src, 5))
        else $error("select latency wrong with resync");

    AST_PIN_SYNC: assert property (
        state_reg.pin_s2 == $past({phase_select_msb, phase_select_lsb, freq_select}, 2))
        else $error("pin synchroniser depth wrong");

    AST_LOAD_DIRECT: assert property (
        (ld_in.valid && state_reg.steady > 4'h9 && !state_reg.resync)
            |-> ##5 (ld_out.valid && ld_out.data == $past(ld_in.data, 5)))
        else $error("load latency wrong without resync");

    AST_LOAD_RESYNC: assert property (
        (ld_in.valid && state_reg.steady > 4'h9 && state_reg.resync)
            |-> ##7 (ld_out.valid && ld_out.data == $past(ld_in.data, 7)))
        else $error("load latency wrong with resync");

    AST_RESET_ZERO: assert property (
        (state_reg.reset_ctl && !state_reg.sleep)
            |=> (state_reg.acc == '0 && state_reg.out_word == '0))
        else $error("reset bit did not zero the phase");

    AST_CLEAR: assert property (
        (cmd_wr && regs.wdata[CMD_OP_HI:CMD_OP_LO] == CMD_OP_PWR && regs.wdata[BIT_CLEAR])
            |=> (!state_reg.resync && !state_reg.select_source))
        else $error("clear left resync or select source set");

    AST_KEEP_REGS: assert property (
        (cmd_wr && !ld_out.valid)
            |=> ($stable(state_reg.freq) && $stable(state_reg.phase)))
        else $error("command write changed a data register");

    AST_RUN_START: assert property (
        (cmd_wr && regs.wdata[CMD_OP_HI:CMD_OP_LO] == CMD_OP_PWR
            && !regs.wdata[BIT_RESET] && state_reg.reset_ctl)
            |=> (!state_reg.reset_ctl && state_reg.run_cnt != '0) [*5]
                ##1 (state_reg.run_cnt == '0))
        else $error("output start delay after reset wrong");

    AST_ACC_STEP: assert property (
        (!hold && !state_reg.sleep)
            |=> state_reg.acc == ACC_W'($past(state_reg.acc) + $past(freq_sel)))
        else $error("accumulator step wrong");

    AST_PHASE_ADD: assert property (
        (!hold && !state_reg.sleep)
            |=> state_reg.out_word
                == PH_W'($past(state_reg.acc[ACC_W-1 -: PH_W]) + $past(phase_sel)))
        else $error("phase offset not added");

    AST_SYNC_CMD: assert property (
        (cmd_wr && regs.wdata[CMD_OP_HI:CMD_OP_LO] == CMD_OP_SYNC)
            |=> (state_reg.resync == $past(regs.wdata[BIT_SYNC])
                && state_reg.select_source == $past(regs.wdata[BIT_SELECT_SOURCE])))
        else $error("resync command not applied");

    AST_SLEEP_CMD: assert property (
        (cmd_wr && regs.wdata[CMD_OP_HI:CMD_OP_LO] == CMD_OP_PWR)
            |=> state_reg.sleep == $past(regs.wdata[BIT_SLEEP]))
        else $error("sleep bit not applied");

    AST_SLEEP_FREEZE: assert property (
        state_reg.sleep |=> ($stable(state_reg.acc) && $stable(state_reg.out_word)))
        else $error("sleep did not freeze the phase");

    AST_START_HOLD: assert property (
        (state_reg.run_cnt != '0 && !state_reg.sleep) |=> state_reg.out_word == '0)
        else $error("phase word moved before start delay ended");

    AST_SEL_BITS: assert property (
        (regs.wr_stb && regs.addr == OFS_SELBITS)
            |=> (state_reg.sel_bits.freq == $past(regs.wdata[SELB_FREQ])
                && state_reg.sel_bits.phase[0] == $past(regs.wdata[SELB_PLSB])
                && state_reg.sel_bits.phase[1] == $past(regs.wdata[SELB_PMSB])))
        else $error("select bits register not written");
endmodule
`default_nettype wire

// ==== tb/ncosl_host_model.sv ====
// Host-side model that drives the register select pins.
// Assumes the bench calls drive from its main sequence.
`timescale 1ns/1ns
`default_nettype none
module ncosl_host_model (
    input  wire logic mclk,
    output logic      freq_select,
    output logic      phase_select_lsb,
    output logic      phase_select_msb
);
    // ==========================================
    // Pin driver
    // Pins low from time zero
    initial begin
        freq_select = 1'b0;
        phase_select_lsb = 1'b0;
        phase_select_msb = 1'b0;
    end
    // Change just after an edge so pin timing holds
    task automatic drive(input logic [2:0] s);
        @(posedge mclk);
        {phase_select_msb, phase_select_lsb, freq_select} <= s;
    endtask
endmodule
`default_nettype wire

// ==== tb/tb_nco_select_latency_control.sv ====
// Self-checking bench of the NCO select/latency core.
// Assumes the core answers APB with no wait states.
`timescale 1ns/1ns
`default_nettype none
module tb_nco_select_latency_control;
    import ncosl_pkg::*;
    logic        mclk = 1'b0;
    logic        nrst = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        fsel;
    logic        plsb;
    logic        pmsb;
    logic [11:0] phase_word;
    logic        sleep_active;
    logic [31:0] rdat;
    logic        rerr;
    int          hit;
    int          n_mismatch = 0;
    int          cmp_count = 0;
    // ==========================================
    // Clock, design and host
    always #50 mclk = ~mclk;
    ncosl_top uut (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .freq_select(fsel),
        .phase_select_lsb(plsb), .phase_select_msb(pmsb),
        .phase_word(phase_word), .sleep_active(sleep_active));
    ncosl_host_model host (.mclk(mclk), .freq_select(fsel),
        .phase_select_lsb(plsb), .phase_select_msb(pmsb));
    // ==========================================
    // Shared tasks
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One APB transfer, held until pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Edge at which the phase step first changes
    task automatic lat;
        logic [11:0] p0;
        logic [11:0] d;
        logic [11:0] d0;
        hit = 0;
        d0 = 12'h000;
        #1;
        p0 = phase_word;
        for (int k = 1; k <= 12; k++) begin
            @(posedge mclk);
            #1;
            d = phase_word - p0;
            p0 = phase_word;
            if (k == 1) d0 = d;
            else if (hit == 0 && d !== d0) hit = k;
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ==========================================
    // Scenarios
    task automatic t_start;
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("reset bit", {31'h0, rdat[ST_RESET]}, 32'h1);
        apb(1'b0, 8'h2C, 32'h0);
        chk("unmapped", {rdat[30:0], rerr}, 32'h1);
        apb(1'b1, OFS_FREQ0, 32'h0010_0000);
        apb(1'b1, OFS_FREQ1, 32'h0020_0000);
        apb(1'b1, OFS_PHASE0, 32'h0);
        apb(1'b1, OFS_PHASE0 + 8'h04, 32'h0000_0400);
        apb(1'b1, OFS_CMD, 32'h0000_C000);
        repeat (6) @(posedge mclk);
        #1 chk("run start", 32'(phase_word), 32'h0);
        @(posedge mclk);
        #1 chk("first step", 32'(phase_word), 32'h1);
        host.drive(3'h2);
        lat();
        chk("pin phase", hit, 6);
        host.drive(3'h3);
        lat();
        chk("pin freq", hit, 7);
        $display("test start and pins done");
    endtask
    task automatic t_bits;
        apb(1'b1, OFS_SELBITS, 32'h3);
        apb(1'b1, OFS_CMD, 32'h0000_9000);
        repeat (12) @(posedge mclk);
        apb(1'b1, OFS_SELBITS, 32'h0);
        lat();
        chk("bit select", hit, 6);
        apb(1'b1, OFS_CMD, 32'h0000_A000);
        repeat (12) @(posedge mclk);
        host.drive(3'h0);
        lat();
        chk("resync pin", hit, 8);
        apb(1'b1, OFS_PHASE0, 32'h0000_0123);
        lat();
        chk("resync load", hit, 8);
        apb(1'b1, OFS_CMD, 32'h0000_C800);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("clear", {30'h0, rdat[ST_SELECT_SOURCE], rdat[ST_RESYNC]}, 32'h0);
        repeat (12) @(posedge mclk);
        apb(1'b1, OFS_PHASE0, 32'h0000_0200);
        lat();
        chk("direct load", hit, 6);
        apb(1'b1, OFS_PHASE3, 32'h0000_0800);
        repeat (8) @(posedge mclk);
        host.drive(3'h6);
        lat();
        chk("pin msb", hit, 6);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("active select", 32'(rdat[ST_SEL_LO +: 3]), 32'h6);
        $display("test bits and resync done");
    endtask
    task automatic t_hold;
        apb(1'b1, OFS_CMD, 32'h0000_D000);
        repeat (8) @(posedge mclk);
        #1 chk("held phase", 32'(phase_word), 32'h0);
        apb(1'b0, OFS_FREQ0, 32'h0);
        chk("kept freq", rdat, 32'h0010_0000);
        apb(1'b1, OFS_CMD, 32'h0000_E000);
        @(posedge mclk);
        #1 chk("sleep", 32'(sleep_active), 32'h1);
        repeat (10) @(posedge mclk);
        #1 chk("frozen", 32'(phase_word), 32'h0);
        $display("test hold done");
    endtask
    // ==========================================
    // Main sequence and watchdog
    initial begin
        repeat (16) @(posedge mclk);
        nrst <= 1'b1;
        t_start();
        t_bits();
        t_hold();
        final_report();
    end
    initial begin
        repeat (3000) @(posedge mclk);
        n_mismatch++;
        final_report();
    end
endmodule
`default_nettype wire
